// File: vdec_irq_pkg.sv
/*
 * Constants for the decoder status and interrupt register block.
 * Assumes an AHB-Lite slave with word registers at four times the index.
 */
// Summary of operation
// - Colour gain field: 00 on, 10 off, 11 frozen
// - Chroma bandwidth select, 00 widest, reset 00
// - Clear-register ones clear matching flags
// - Flag bits 7,5..0 used; bit 6 reserved
// - Mask bits enable flags onto interrupt pin
// - Masking never stops flags from setting
// - Pin asserted when any flag and enable
// - Polarity bit 0: 0 low, 1 high default
// - Low: drive low or float; high: drive
// - Program port writes go to program RAM
// - Any restart write releases the microprocessor
// - Revision register returns major firmware revision
// - Status one: peak white, alternation, rate
// - Lost lock sticky until status one read
// - Status one: locks and TV/VCR bit
// - Status two: PAL switch, field, AGC
// - Odd field reads one; frozen AGC one
// - Flags polled at 85h, cleared via 1Ch
package vdec_irq_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CHROMA_CTRL  = 8'h1a;
    localparam logic [7:0] IDX_CHROMA_BW    = 8'h1b;
    localparam logic [7:0] IDX_FLAG_CLEAR   = 8'h1c;
    localparam logic [7:0] IDX_MASK         = 8'h1d;
    localparam logic [7:0] IDX_POLARITY     = 8'h1e;
    localparam logic [7:0] IDX_PROG_WRITE   = 8'h7e;
    localparam logic [7:0] IDX_CPU_RESTART  = 8'h7f;
    localparam logic [7:0] IDX_FW_MAJOR     = 8'h80;
    localparam logic [7:0] IDX_LOCK_STATUS  = 8'h81;
    localparam logic [7:0] IDX_FIELD_STATUS = 8'h82;
    localparam logic [7:0] IDX_FLAG_STATUS  = 8'h85;
    localparam logic [7:0] IDX_IRQ_ACTIVE   = 8'h86;

    localparam logic [1:0] GAIN_ENABLED  = 2'h0;
    localparam logic [1:0] GAIN_DISABLED = 2'h2;
    localparam logic [1:0] GAIN_FROZEN   = 2'h3;
    localparam logic [1:0] GAIN_RESET    = GAIN_ENABLED;
    localparam logic [1:0] BW_RESET      = 2'h0;
    localparam logic [7:0] MASK_RESET    = 8'h00;
    localparam logic       POL_RESET     = 1'b1;

    // Flag bit positions
    localparam int FLAG_SW_INIT   = 7;
    localparam int FLAG_RESERVED  = 6;
    localparam int FLAG_CMD_READY = 5;
    localparam int FLAG_RATE      = 4;
    localparam int FLAG_ALT       = 3;
    localparam int FLAG_COLOR     = 2;
    localparam int FLAG_SYNC      = 1;
    localparam int FLAG_TV_VCR    = 0;
    localparam logic [7:0] FLAG_IMPL = 8'hbf;

    localparam int POL_BIT      = 0;
    localparam int ST1_LOST_POS = 4;
    localparam int ST2_PAL_POS  = 5;
    localparam int ST2_ODD_POS  = 4;
    localparam int ST2_AGC_POS  = 3;
endpackage

// File: vdec_irq_regs.sv
/*
 * Status, chroma control and interrupt register block of a video decoder,
 * reached over AHB-Lite with one wait state on every transfer.
 * Assumes event and status inputs come from logic on core_clk.
 */
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ps
module vdec_irq_regs
    import vdec_irq_pkg::*;
#(
    parameter int PROG_ADDR_W = 12
) (
    input  wire logic                   core_clk,
    input  wire logic                   arst_n,
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic [31:0]                 hrdata,
    output logic                        hreadyout,
    output logic                        hresp,
    input  wire logic [7:0]             irq_event,
    input  wire logic                   lock_lost,
    input  wire logic                   peak_white,
    input  wire logic                   line_alternating,
    input  wire logic                   field_rate_50,
    input  wire logic                   color_locked,
    input  wire logic                   vsync_locked,
    input  wire logic                   hsync_locked,
    input  wire logic                   vcr_source,
    input  wire logic                   pal_switch,
    input  wire logic                   odd_field,
    input  wire logic                   agc_frozen,
    input  wire logic [7:0]             fw_major_rev,
    output logic [1:0]                  auto_chroma_gain,
    output logic [1:0]                  chroma_bw_sel,
    output logic                        irq_pin_o,
    output logic                        irq_pin_oe,
    output logic                        cpu_hold,
    output logic                        prog_we,
    output logic [PROG_ADDR_W-1:0]      prog_addr,
    output logic [7:0]                  prog_data
);

    // Elaboration-time refusal of address widths the counter cannot serve
    if (PROG_ADDR_W < 1 || PROG_ADDR_W > 24) begin : g_bad_width
        $error("PROG_ADDR_W out of range");
    end

    typedef struct packed {
        logic [1:0]             gain;
        logic [1:0]             bw;
        logic [7:0]             mask;
        logic                   pol;
        logic [7:0]             flags;
        logic                   lost;
        logic                   hold;
        logic                   we;
        logic [PROG_ADDR_W-1:0] paddr;
        logic [7:0]             pdata;
        logic [31:0]            rdata;
        logic                   rdy;
        logic                   pend;
        logic                   pend_wr;
        logic [7:0]             pend_idx;
        logic                   pin_o;
        logic                   pin_oe;
    } state_t;

    state_t s;
    state_t next_s;

    logic       take;
    logic       mapped;
    logic       do_wr;
    logic       do_rd;
    logic [7:0] wbyte;
    logic [7:0] set_bits;
    logic [7:0] st1;
    logic [7:0] st2;
    logic       active;
    logic       pin_asserted;

    // Only word-aligned accesses inside the low 1 KiB decode to registers; hsize is not checked
    assign take   = hsel && htrans[1] && hready;
    assign mapped = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
    assign do_wr  = s.pend && s.pend_wr;
    assign do_rd  = s.pend && !s.pend_wr;
    assign wbyte  = hwdata[7:0];
    // Reserved flag position never sets
    assign set_bits = irq_event & FLAG_IMPL;

    // Status one: peak, alternation, rate, lost, colour, v, h, source
    assign st1 = {peak_white, line_alternating, field_rate_50,
                  s.lost, color_locked, vsync_locked,
                  hsync_locked, vcr_source};

    always_comb begin
        st2 = 8'h00;
        st2[ST2_PAL_POS] = pal_switch;
        st2[ST2_ODD_POS] = odd_field;
        st2[ST2_AGC_POS] = agc_frozen;
    end

    always_comb begin
        next_s    = s;
        next_s.we = 1'b0;

        // Flags set regardless of mask; set wins over a same-cycle clear
        if (do_wr && s.pend_idx == IDX_FLAG_CLEAR) begin
            next_s.flags = s.flags & ~wbyte;
        end
        next_s.flags = next_s.flags | set_bits;

        // Reading status one rearms the lost-lock indicator
        if (do_rd && s.pend_idx == IDX_LOCK_STATUS) begin
            next_s.lost = 1'b0;
        end
        if (lock_lost) begin
            next_s.lost = 1'b1;
        end

        if (do_wr) begin
            case (s.pend_idx)
                IDX_CHROMA_CTRL: begin
                    // Reserved gain code 01 is stored as written
                    next_s.gain = wbyte[1:0];
                end
                IDX_CHROMA_BW: begin
                    next_s.bw = wbyte[1:0];
                end
                IDX_MASK: begin
                    next_s.mask = wbyte & FLAG_IMPL;
                end
                IDX_POLARITY: begin
                    next_s.pol = wbyte[POL_BIT];
                end
                IDX_PROG_WRITE: begin
                    next_s.we    = 1'b1;
                    next_s.pdata = wbyte;
                end
                IDX_CPU_RESTART: begin
                    next_s.hold = 1'b0;
                end
                default: begin
                end
            endcase
        end
        // Download address steps after each stored byte
        if (s.we) begin
            next_s.paddr = s.paddr + PROG_ADDR_W'(1);
        end

        if (do_rd) begin
            case (s.pend_idx)
                IDX_CHROMA_CTRL:  next_s.rdata = {30'h0, s.gain};
                IDX_CHROMA_BW:    next_s.rdata = {30'h0, s.bw};
                IDX_MASK:         next_s.rdata = {24'h0, s.mask};
                IDX_POLARITY:     next_s.rdata = {31'h0, s.pol};
                IDX_FW_MAJOR:     next_s.rdata = {24'h0, fw_major_rev};
                IDX_LOCK_STATUS:  next_s.rdata = {24'h0, st1};
                IDX_FIELD_STATUS: next_s.rdata = {24'h0, st2};
                IDX_FLAG_STATUS:  next_s.rdata = {24'h0, s.flags};
                IDX_IRQ_ACTIVE:   next_s.rdata = {31'h0, pin_asserted};
                default:          next_s.rdata = 32'h0;
            endcase
        end

        // One wait state: data phase answered on the second cycle
        if (s.pend) begin
            next_s.pend = 1'b0;
            next_s.rdy  = 1'b1;
        end else if (take) begin
            next_s.pend     = 1'b1;
            next_s.rdy      = 1'b0;
            next_s.pend_wr  = hwrite && mapped;
            next_s.pend_idx = mapped ? haddr[9:2] : 8'hff;
        end
    end

    // Pin follows the stored flags and mask of the coming cycle
    always_comb begin
        active = |(next_s.flags & next_s.mask);
    end

    state_t final_s;
    always_comb begin
        final_s = next_s;
        if (next_s.pol) begin
            final_s.pin_o  = active;
            final_s.pin_oe = 1'b1;
        end else begin
            // Open-collector: float when idle
            final_s.pin_o  = 1'b0;
            final_s.pin_oe = active;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s          <= '0;
            s.gain     <= GAIN_RESET;
            s.bw       <= BW_RESET;
            s.mask     <= MASK_RESET;
            s.pol      <= POL_RESET;
            s.hold     <= 1'b1;
            s.rdy      <= 1'b1;
            s.pin_oe   <= POL_RESET;
        end else begin
            s <= final_s;
        end
    end

    assign hrdata           = s.rdata;
    assign hreadyout        = s.rdy;
    assign hresp            = 1'b0;
    assign auto_chroma_gain = s.gain;
    assign chroma_bw_sel    = s.bw;
    assign irq_pin_o        = s.pin_o;
    assign irq_pin_oe       = s.pin_oe;
    assign cpu_hold         = s.hold;
    assign prog_we          = s.we;
    assign prog_addr        = s.paddr;
    assign prog_data        = s.pdata;

    // Asserted level depends on polarity: driven high, or driven at all
    assign pin_asserted = s.pol ? s.pin_o : s.pin_oe;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);

    flag_set_a: assert property (
        |set_bits |=> (s.flags & $past(set_bits)) == $past(set_bits))
        else $error("event did not set its flag");

    flag_clear_a: assert property (
        do_wr && s.pend_idx == IDX_FLAG_CLEAR && set_bits == 8'h00
        |=> (s.flags & $past(wbyte)) == 8'h00
            && (s.flags & ~$past(wbyte)) == ($past(s.flags) & ~$past(wbyte)))
        else $error("flag clear wrong");

    irq_level_a: assert property (
        pin_asserted == |(s.flags & s.mask))
        else $error("pin does not match flags and mask");

    pin_drive_a: assert property (
        !s.pol |-> !s.pin_o)
        else $error("active-low pin driven high");

    lost_read_a: assert property (
        do_rd && s.pend_idx == IDX_LOCK_STATUS && !lock_lost
        |=> !s.lost ##1 hrdata[ST1_LOST_POS] == $past(s.lost, 2))
        else $error("lost lock not rearmed by read");

    cpu_restart_a: assert property (
        do_wr && s.pend_idx == IDX_CPU_RESTART |=> !cpu_hold)
        else $error("restart write ignored");

    // Once released the microprocessor stays running until reset
    hold_release_a: assert property (
        !cpu_hold |=> !cpu_hold)
        else $error("microprocessor held again");

    prog_write_a: assert property (
        do_wr && s.pend_idx == IDX_PROG_WRITE
        |=> prog_we && prog_data == $past(wbyte) ##1 !prog_we)
        else $error("program byte not written");

    bus_wait_a: assert property (
        take && !s.pend |=> !hreadyout ##1 hreadyout)
        else $error("wait state wrong");

    // Writable fields take the byte at the edge that ends the wait state
    gain_write_a: assert property (
        do_wr && s.pend_idx == IDX_CHROMA_CTRL
        |=> auto_chroma_gain == $past(wbyte[1:0]))
        else $error("gain field not written");

    bw_write_a: assert property (
        do_wr && s.pend_idx == IDX_CHROMA_BW
        |=> chroma_bw_sel == $past(wbyte[1:0]))
        else $error("bandwidth field not written");

    mask_write_a: assert property (
        do_wr && s.pend_idx == IDX_MASK
        |=> s.mask == ($past(wbyte) & FLAG_IMPL))
        else $error("mask not written");

    pol_write_a: assert property (
        do_wr && s.pend_idx == IDX_POLARITY
        |=> s.pol == $past(wbyte[POL_BIT]))
        else $error("polarity not written");

    pin_high_a: assert property (
        s.pol |-> s.pin_oe)
        else $error("active-high pin not driven");

    // Flags move only through an event or a clear write
    flag_hold_a: assert property (
        set_bits == 8'h00 && !(do_wr && s.pend_idx == IDX_FLAG_CLEAR)
        |=> s.flags == $past(s.flags))
        else $error("flags changed without cause");

    flag_read_a: assert property (
        do_rd && s.pend_idx == IDX_FLAG_STATUS
        |=> hrdata == {24'h0, $past(s.flags)})
        else $error("flag status read wrong");

    active_read_a: assert property (
        do_rd && s.pend_idx == IDX_IRQ_ACTIVE
        |=> hrdata == {31'h0, $past(|(s.flags & s.mask))})
        else $error("active bit read wrong");

    lost_set_a: assert property (
        lock_lost |=> s.lost)
        else $error("lost lock not recorded");

    rev_read_a: assert property (
        do_rd && s.pend_idx == IDX_FW_MAJOR
        |=> hrdata == {24'h0, $past(fw_major_rev)})
        else $error("revision read wrong");

    status_one_a: assert property (
        do_rd && s.pend_idx == IDX_LOCK_STATUS
        |=> hrdata[7:5] == $past({peak_white, line_alternating,
                                  field_rate_50})
            && hrdata[3:0] == $past({color_locked, vsync_locked,
                                     hsync_locked, vcr_source}))
        else $error("status one read wrong");

    status_two_a: assert property (
        do_rd && s.pend_idx == IDX_FIELD_STATUS
        |=> hrdata[ST2_PAL_POS] == $past(pal_switch)
            && hrdata[ST2_ODD_POS] == $past(odd_field)
            && hrdata[ST2_AGC_POS] == $past(agc_frozen))
        else $error("status two read wrong");

    // Download address must not skip or repeat a location
    addr_step_a: assert property (
        prog_we |=> prog_addr == $past(prog_addr) + PROG_ADDR_W'(1))
        else $error("program address did not step");

    cover_clear_c: cover property (do_wr && s.pend_idx == IDX_FLAG_CLEAR);
    cover_pin_c:   cover property (!s.pol && s.pin_oe);
    cover_lost_c:  cover property (do_rd && s.pend_idx == IDX_LOCK_STATUS
                                  && s.lost);
    cover_race_c:  cover property (do_wr && s.pend_idx == IDX_FLAG_CLEAR
                                  && |(set_bits & wbyte));
    cover_boot_c:  cover property (do_wr && s.pend_idx == IDX_CPU_RESTART);

endmodule // vdec_irq_regs

// File: host_model.sv
/*
 * Host processor model: single word AHB-Lite transfers to the block.
 * Assumes hready is the slave's hreadyout and that transfers are serialised.
 */
`timescale 1ns/1ps
module host_model (
    input  wire logic        core_clk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    logic pol_a;
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        pol_a = 1'b1;
    end
    task automatic xfer(input logic w, input logic [7:0] idx,
                        input logic [7:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {22'h0, idx, 2'h0};
        hwrite <= w;
        @(posedge core_clk);
        while (hready !== 1'b1) @(posedge core_clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        @(posedge core_clk);
        while (hready !== 1'b1) @(posedge core_clk);
        r = hrdata;
        // Stale write data must not look valid
        hwdata <= ~hwdata;
    endtask
    // Pin polarity is set by writing bit 0 of the polarity register
    task automatic set_pol(input logic p);
        logic [31:0] r;
        pol_a = p;
        xfer(1'b1, 8'h1e, {7'h0, pol_a}, r);
    endtask
endmodule // host_model

// File: tb_vdec_irq_regs.sv
/*
 * Self-checking bench for the status and interrupt register block.
 * Assumes the host model drives the bus; interrupt line has a pull-up.
 */
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module tb_vdec_irq_regs;
    import vdec_irq_pkg::*;
    logic core_clk, arst_n, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans, auto_chroma_gain, chroma_bw_sel;
    logic [2:0]  hsize;
    logic [7:0]  irq_event, fw_major_rev, prog_addr, prog_data;
    logic        lock_lost, irq_pin_o, irq_pin_oe, cpu_hold, prog_we;
    logic [9:0]  lv;
    int          bad_count, checked, cyc;
    logic [15:0] pq[$];
    tri1         irq_line;
    assign irq_line = irq_pin_oe ? irq_pin_o : 1'bz;

    host_model host (.core_clk(core_clk), .hready(hreadyout),
        .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    vdec_irq_regs #(.PROG_ADDR_W(8)) dut (.core_clk(core_clk),
        .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .irq_event(irq_event), .lock_lost(lock_lost),
        .peak_white(lv[9]), .line_alternating(lv[8]),
        .field_rate_50(lv[7]), .color_locked(lv[6]),
        .vsync_locked(lv[5]), .hsync_locked(lv[4]), .vcr_source(lv[3]),
        .pal_switch(lv[2]), .odd_field(lv[1]), .agc_frozen(lv[0]),
        .fw_major_rev(fw_major_rev), .auto_chroma_gain(auto_chroma_gain),
        .chroma_bw_sel(chroma_bw_sel), .irq_pin_o(irq_pin_o),
        .irq_pin_oe(irq_pin_oe), .cpu_hold(cpu_hold), .prog_we(prog_we),
        .prog_addr(prog_addr), .prog_data(prog_data));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        if (prog_we === 1'b1) pq.push_back({prog_addr, prog_data});
        cyc++;
        if (cyc == 6000) begin
            bad_count++;
            test_done();
        end
    end

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] r;
        host.xfer(1'b1, idx, d, r);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] e);
        logic [31:0] r;
        host.xfer(1'b0, idx, 8'h0, r);
        `CHK(r, {24'h0, e})
    endtask
    task automatic pulse(input logic [7:0] e, input logic l);
        irq_event <= e;
        lock_lost <= l;
        @(posedge core_clk);
        irq_event <= 8'h0;
        lock_lost <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic settle;
        repeat (2) @(posedge core_clk);
    endtask

    task automatic t_reset;
        rd(IDX_CHROMA_CTRL, 8'h00);
        rd(IDX_CHROMA_BW, 8'h00);
        rd(IDX_POLARITY, 8'h01);
        rd(IDX_MASK, 8'h00);
        rd(IDX_FLAG_STATUS, 8'h00);
        rd(8'h3f, 8'h00);
        `CHK(irq_line, 1'b0)
        `CHK(cpu_hold, 1'b1)
    endtask
    task automatic t_chroma;
        logic [1:0] g[3] = '{GAIN_ENABLED, GAIN_DISABLED, GAIN_FROZEN};
        for (int i = 0; i < 3; i++) begin
            wr(IDX_CHROMA_CTRL, {6'h0, g[i]});
            `CHK(auto_chroma_gain, g[i])
            rd(IDX_CHROMA_CTRL, {6'h0, g[i]});
        end
        for (int i = 3; i >= 0; i--) begin
            wr(IDX_CHROMA_BW, 8'(i));
            `CHK(chroma_bw_sel, 2'(i))
            rd(IDX_CHROMA_BW, 8'(i));
        end
    endtask
    task automatic t_flags;
        pulse(8'hff, 1'b0);
        rd(IDX_FLAG_STATUS, 8'hbf);
        settle();
        `CHK(irq_line, 1'b0)
        wr(IDX_FLAG_CLEAR, 8'h05);
        rd(IDX_FLAG_STATUS, 8'hba);
        wr(IDX_MASK, 8'h20);
        settle();
        `CHK(irq_line, 1'b1)
        rd(IDX_IRQ_ACTIVE, 8'h01);
        wr(IDX_FLAG_CLEAR, 8'h20);
        settle();
        `CHK(irq_line, 1'b0)
        fork
            wr(IDX_FLAG_CLEAR, 8'h01);
            begin
                @(posedge core_clk);
                irq_event <= 8'h01;
                @(posedge core_clk);
                irq_event <= 8'h00;
            end
        join
        rd(IDX_FLAG_STATUS, 8'h9b);
    endtask
    task automatic t_pol;
        host.set_pol(1'b0);
        wr(IDX_MASK, 8'h01);
        settle();
        `CHK({irq_pin_oe, irq_line}, 2'b10)
        wr(IDX_FLAG_CLEAR, 8'hff);
        settle();
        `CHK({irq_pin_oe, irq_line}, 2'b01)
        host.set_pol(1'b1);
        settle();
        `CHK({irq_pin_oe, irq_line}, 2'b10)
        wr(IDX_MASK, 8'hff);
        rd(IDX_MASK, 8'hbf);
    endtask
    task automatic t_prog;
        wr(IDX_PROG_WRITE, 8'ha5);
        wr(IDX_PROG_WRITE, 8'h3c);
        settle();
        `CHK(pq.size(), 2)
        `CHK(pq[0], 16'h00a5)
        `CHK(pq[1], 16'h013c)
        `CHK(cpu_hold, 1'b1)
        wr(IDX_CPU_RESTART, 8'h5a);
        `CHK(cpu_hold, 1'b0)
    endtask
    task automatic t_status;
        logic [9:0] p[3] = '{10'h3ff, 10'h2aa, 10'h155};
        for (int i = 0; i < 3; i++) begin
            lv <= p[i];
            fw_major_rev <= {p[i][7:0]};
            @(posedge core_clk);
            rd(IDX_FW_MAJOR, p[i][7:0]);
            rd(IDX_LOCK_STATUS, {p[i][9:7], 1'b0, p[i][6:3]});
            rd(IDX_FIELD_STATUS, {2'h0, p[i][2:0], 3'h0});
        end
        pulse(8'h00, 1'b1);
        rd(IDX_LOCK_STATUS, {p[2][9:7], 1'b1, p[2][6:3]});
        rd(IDX_LOCK_STATUS, {p[2][9:7], 1'b0, p[2][6:3]});
    endtask

    task automatic test_done;
        $display("Mismatches %0d of %0d comparisons", bad_count, checked);
        if (bad_count == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        arst_n = 1'b0;
        irq_event = 8'h0;
        lock_lost = 1'b0;
        lv = 10'h0;
        fw_major_rev = 8'h0;
        bad_count = 0;
        checked = 0;
        cyc = 0;
        repeat (5) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        t_reset();
        t_chroma();
        t_flags();
        t_pol();
        t_prog();
        t_status();
        test_done();
    end
endmodule // tb_vdec_irq_regs
